/* common/pgs_cfg.svh */
// pgs_cfg.svh: register offsets, field positions, reset values and cycle counts
// for the power-good and fault sequencer. Definitions only.
`ifndef PGS_CFG_SVH
`define PGS_CFG_SVH

// apb register byte offsets
`define PGS_ADDR_W 8
`define PGS_OFF_CTRL 8'h00
`define PGS_OFF_STATUS 8'h04
`define PGS_OFF_PGCNT 8'h08

// ctrl: switching period in pclk cycles, bits 15:0
`define PGS_PERIOD_LSB 0
`define PGS_PERIOD_W 16
// 250 MHz / 250 gives a 1 MHz switching clock after reset
`define PGS_PERIOD_RST 16'h00fa
// shorter periods are refused; below 2 the half-period phase point collides with the cycle start
`define PGS_PERIOD_MIN 16'h0004

// status field positions
`define PGS_ST_PG_BIT 0
`define PGS_ST_LIN_BIT 1
`define PGS_ST_CH0_LSB 4
`define PGS_ST_CH1_LSB 8

// power-good delay: 0.5236 s*MHz, i.e. 0.5236e6 switching cycles
`define PGS_PG_DELAY_MICRO 5236
`define PGS_PG_DELAY_CYC (`PGS_PG_DELAY_MICRO * 100)
`define PGS_PGC_W 20

// consecutive-cycle fault limits
`define PGS_OC_LIMIT 6'h20
`define PGS_OV_LIMIT 6'h20
`define PGS_UV_LIMIT 4'h8

`endif

/* common/pgs_pkg.sv */
// pgs_pkg: types of the power-good and fault sequencer.
// assumes pgs_cfg.svh supplies the widths.
`include "pgs_cfg.svh"

package pgs_pkg;

    // per-channel protection state
    typedef enum logic [2:0] {
        CH_OFF,
        CH_SOFT,
        CH_RUN,
        CH_HICCUP,
        CH_OVLATCH
    } pgs_ch_state_t;

    // comparator results of one switcher channel, synchronous to pclk
    typedef struct packed {
        logic ss_en;     // soft-start/enable pin above 1 V
        logic ss_done;   // soft-start ramp reached about 3.2 V
        logic win_ok;    // feedback inside the 90%..110% window
        logic uv;        // feedback at or below 82% of reference
        logic ov;        // feedback at or above 116% of reference
        logic oc_cmp;    // switch node below overcurrent_threshold_pin
        logic pwm_end;   // modulator ends the upper pulse
        logic ind_rev;   // inductor current reversed (diode emulation)
    } pgs_ch_in_t;

    // per-channel registered state
    typedef struct packed {
        pgs_ch_state_t st;
        logic [5:0] oc_cnt;
        logic [3:0] uv_cnt;
        logic [5:0] ov_cnt;
        logic oc_seen;
        logic ug;
        logic lg;
        logic oe;
        logic dis;
    } pgs_ch_t;

    // whole state of the sequencer
    typedef struct packed {
        pgs_ch_t [1:0] ch;
        logic [`PGS_PERIOD_W-1:0] period;
        logic [`PGS_PERIOD_W-1:0] pcnt;
        logic [`PGS_PGC_W-1:0] pg_cnt;
        logic pg_good;
        logic pg_oe;
        logic lin_on;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pgs_state_t;

endpackage : pgs_pkg

/* rtl/pgs_sequencer.sv */
// pgs_sequencer: digital supervision of a dual buck controller with a linear
// output: switching phase generation, gate sequencing, fault protection and
// the delayed power-good output.
// assumes all comparator inputs are synchronous to pclk and presetn is the
// power-on reset (asserted below the falling trip point).
`timescale 1ns/1ps
`default_nettype none
`include "pgs_cfg.svh"

// Notes on behaviour
// - qualify needs both ramps done, windows ok
// - delay is 0.5236/fsw(MHz) seconds
// - release power-good pull-down on timeout
// - any failed condition drops power-good immediately
// - recovery restarts a complete new delay
// - delay counts switching cycles only
// - lower gate off during soft-start unless overvoltage
// - channels run half a period apart
// - linear on after reset, no ramp
// - overcurrent when switch node low, upper on
// - overcurrent ends upper pulse, counts cycle
// - 32 overcurrent cycles outside soft-start hiccup
// - hiccup discharges soft-start, then fresh ramp
// - soft-start limits pulses, holds counter cleared
// - hiccup repeats forever, clean ramp resumes
// - 8 undervoltage cycles enter hiccup
// - overvoltage holds lower gate on, emulating diode
// - 32 overvoltage cycles latch off, tri-state
// - latch clears by disable, reset or undervoltage
// - soft-start done signal from ramp end
module pgs_sequencer
    import pgs_pkg::*;
#(
    parameter int PG_DELAY_CYC = `PGS_PG_DELAY_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PGS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // comparator results
    input wire pgs_ch_in_t [1:0] ch_in,
    input wire logic lin_ok,
    // gate drive, per channel
    output logic [1:0] upper_gate_drive,
    output logic [1:0] lower_gate_drive,
    output logic [1:0] gate_drive_oe,
    output logic [1:0] ss_discharge,
    // open-drain power-good and linear drive
    output logic power_good_out,
    output logic power_good_oe,
    output logic linear_drive_out
);

    localparam logic [`PGS_PGC_W-1:0] PG_LAST = `PGS_PGC_W'(PG_DELAY_CYC - 1);

    // refuse a delay the counter cannot hold
    if (PG_DELAY_CYC < 1 || PG_DELAY_CYC > (2 ** `PGS_PGC_W) - 1) begin : g_bad_delay
        $error("pgs_sequencer: PG_DELAY_CYC out of range");
    end

    pgs_state_t s_q;
    pgs_state_t s_d;
    logic [1:0] cyc_start;
    logic pg_cond;

    // phase points: channel 0 at count 0, channel 1 half a period later
    // anti-phase starts
    assign cyc_start[0] = (s_q.pcnt == '0);
    assign cyc_start[1] = (s_q.pcnt == (s_q.period >> 1));

    // qualifying conditions for power-good
    // qualify conditions
    assign pg_cond = ch_in[0].ss_done && ch_in[1].ss_done && ch_in[0].win_ok && ch_in[1].win_ok && lin_ok;

    // next-state logic of the whole block
    always_comb begin
        logic active;
        logic counting;
        logic ug_n;
        logic [5:0] oc_n;
        logic [3:0] uv_n;
        logic [5:0] ov_n;
        logic acc;
        active = 1'b0;
        counting = 1'b0;
        ug_n = 1'b0;
        oc_n = '0;
        uv_n = '0;
        ov_n = '0;
        acc = 1'b0;
        s_d = s_q;

        // switching period counter, wraps also when the period shrinks
        if (s_q.pcnt >= s_q.period - 16'h0001) begin
            s_d.pcnt = '0;
        end else begin
            s_d.pcnt = s_q.pcnt + 16'h0001;
        end

        s_d.lin_on = 1'b1;

        for (int i = 0; i < 2; i++) begin
            active = (s_q.ch[i].st == CH_SOFT) || (s_q.ch[i].st == CH_RUN);
            oc_n = s_q.ch[i].oc_cnt;
            uv_n = s_q.ch[i].uv_cnt;
            ov_n = s_q.ch[i].ov_cnt;

            if (cyc_start[i]) begin
                oc_n = (s_q.ch[i].st == CH_RUN && s_q.ch[i].oc_seen) ?
                       ((oc_n < `PGS_OC_LIMIT) ? oc_n + 6'h01 : oc_n) : 6'h00;
                counting = (s_q.ch[i].st == CH_RUN) || (s_q.ch[i].st == CH_OVLATCH);
                uv_n = (counting && ch_in[i].uv) ?
                       ((uv_n < `PGS_UV_LIMIT) ? uv_n + 4'h1 : uv_n) : 4'h0;
                // overvoltage counted once soft-start is done
                ov_n = (s_q.ch[i].st == CH_RUN && ch_in[i].ov) ?
                       ((ov_n < `PGS_OV_LIMIT) ? ov_n + 6'h01 : ov_n) : 6'h00;
            end
            s_d.ch[i].oc_cnt = oc_n;
            s_d.ch[i].uv_cnt = uv_n;
            s_d.ch[i].ov_cnt = ov_n;

            // channel state transitions
            case (s_q.ch[i].st)
                CH_OFF: begin
                    if (ch_in[i].ss_en) begin
                        s_d.ch[i].st = CH_SOFT;
                    end
                end
                CH_SOFT: begin
                    if (!ch_in[i].ss_en) begin
                        s_d.ch[i].st = CH_OFF;
                    end else if (ch_in[i].ss_done) begin
                        s_d.ch[i].st = CH_RUN;
                    end
                end
                CH_RUN: begin
                    if (!ch_in[i].ss_en) begin
                        s_d.ch[i].st = CH_OFF;
                    end else if (oc_n == `PGS_OC_LIMIT || uv_n == `PGS_UV_LIMIT) begin
                        s_d.ch[i].st = CH_HICCUP;
                    end else if (ov_n == `PGS_OV_LIMIT) begin
                        s_d.ch[i].st = CH_OVLATCH;
                    end
                end
                CH_HICCUP: begin
                    if (!ch_in[i].ss_en) begin
                        s_d.ch[i].st = CH_OFF;
                    end
                end
                CH_OVLATCH: begin
                    if (!ch_in[i].ss_en) begin
                        s_d.ch[i].st = CH_OFF;
                    end else if (uv_n == `PGS_UV_LIMIT) begin
                        s_d.ch[i].st = CH_HICCUP;
                    end
                end
                default: begin
                    s_d.ch[i].st = CH_OFF;
                end
            endcase

            // counters only live while their state counts
            if (s_d.ch[i].st != CH_RUN) begin
                s_d.ch[i].oc_cnt = '0;
                s_d.ch[i].ov_cnt = '0;
            end
            if (s_d.ch[i].st != CH_RUN && s_d.ch[i].st != CH_OVLATCH) begin
                s_d.ch[i].uv_cnt = '0;
            end

            // upper gate: set at cycle start, ended by modulator or overcurrent
            ug_n = s_q.ch[i].ug;
            s_d.ch[i].oc_seen = s_q.ch[i].oc_seen;
            if (cyc_start[i]) begin
                ug_n = active && !ch_in[i].ov;
                s_d.ch[i].oc_seen = 1'b0;
            end else if (s_q.ch[i].ug && ch_in[i].oc_cmp) begin
                ug_n = 1'b0;
                s_d.ch[i].oc_seen = 1'b1;
            end else if (ch_in[i].pwm_end || ch_in[i].ov) begin
                ug_n = 1'b0;
            end
            if (s_d.ch[i].st != CH_SOFT && s_d.ch[i].st != CH_RUN) begin
                ug_n = 1'b0;
            end
            s_d.ch[i].ug = ug_n;

            // lower gate
            if ((s_d.ch[i].st == CH_SOFT || s_d.ch[i].st == CH_RUN) && ch_in[i].ov) begin
                s_d.ch[i].lg = !ch_in[i].ind_rev;
            end else begin
                s_d.ch[i].lg = (s_d.ch[i].st == CH_RUN) && !ug_n;
            end

            s_d.ch[i].oe = (s_d.ch[i].st != CH_OVLATCH);
            s_d.ch[i].dis = (s_d.ch[i].st == CH_HICCUP);
        end

        // power-good qualification timer
        // the wait scales with the programmed period: there is no separate delay
        // setting, so a slower switching clock simply waits longer
        if (!pg_cond) begin
            s_d.pg_cnt = '0;
            s_d.pg_good = 1'b0;
        end else if (!s_q.pg_good && cyc_start[0]) begin
            if (s_q.pg_cnt == PG_LAST) begin
                s_d.pg_good = 1'b1;
            end else begin
                s_d.pg_cnt = s_q.pg_cnt + `PGS_PGC_W'(1);
            end
        end
        s_d.pg_oe = !s_d.pg_good;

        // apb: decode in setup, answer in the following access cycle
        acc = psel && penable && s_q.pready;
        s_d.pready = 1'b0;
        if (psel && !penable) begin
            s_d.pready = 1'b1;
            s_d.pslverr = 1'b0;
            s_d.prdata = '0;
            case (paddr)
                `PGS_OFF_CTRL: begin
                    s_d.prdata[`PGS_PERIOD_LSB +: `PGS_PERIOD_W] = s_q.period;
                    // too short a period is refused
                    s_d.pslverr = pwrite && (pwdata[`PGS_PERIOD_LSB +: `PGS_PERIOD_W] < `PGS_PERIOD_MIN);
                end
                `PGS_OFF_STATUS: begin
                    s_d.prdata[`PGS_ST_PG_BIT] = s_q.pg_good;
                    s_d.prdata[`PGS_ST_LIN_BIT] = s_q.lin_on;
                    s_d.prdata[`PGS_ST_CH0_LSB +: 3] = s_q.ch[0].st;
                    s_d.prdata[`PGS_ST_CH1_LSB +: 3] = s_q.ch[1].st;
                    s_d.pslverr = pwrite;
                end
                `PGS_OFF_PGCNT: begin
                    s_d.prdata[`PGS_PGC_W-1:0] = s_q.pg_cnt;
                    s_d.pslverr = pwrite;
                end
                default: begin
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        // write lands on the completing edge only
        if (acc && pwrite && !s_q.pslverr && paddr == `PGS_OFF_CTRL) begin
            s_d.period = pwdata[`PGS_PERIOD_LSB +: `PGS_PERIOD_W];
        end
    end

    // state register; reset loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.period <= `PGS_PERIOD_RST;
            s_q.pg_oe <= 1'b1;
            for (int i = 0; i < 2; i++) begin
                s_q.ch[i].st <= CH_OFF;
                s_q.ch[i].oe <= 1'b1;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register, power_good_out tied low
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign power_good_out = 1'b0;   // open drain only ever pulls low
    assign power_good_oe = s_q.pg_oe;
    assign linear_drive_out = s_q.lin_on;
    for (genvar g = 0; g < 2; g++) begin : g_out
        assign upper_gate_drive[g] = s_q.ch[g].ug;
        assign lower_gate_drive[g] = s_q.ch[g].lg;
        assign gate_drive_oe[g] = s_q.ch[g].oe;
        assign ss_discharge[g] = s_q.ch[g].dis;
    end

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    pg_qualify_a: assert property (!pg_cond |=> s_q.pg_cnt == '0 && power_good_oe)
        else $error("power-good counter not held while unqualified");
    pg_drop_a: assert property (!power_good_oe && !pg_cond |=> power_good_oe)
        else $error("power-good not dropped on failed condition");
    pg_release_a: assert property ($fell(power_good_oe) |-> $past(s_q.pg_cnt) == PG_LAST)
        else $error("power-good released before full delay");
    pg_step_a: assert property (s_q.pg_cnt != $past(s_q.pg_cnt) && s_q.pg_cnt != '0
        |-> $past(cyc_start[0]))
        else $error("delay counter stepped off a switching cycle");

    // per-channel checks, one copy for each switcher
    for (genvar g = 0; g < 2; g++) begin : g_chk
        soft_low_a: assert property (s_q.ch[g].st == CH_SOFT && !$past(ch_in[g].ov)
            |-> !lower_gate_drive[g] && s_q.ch[g].oc_cnt == '0)
            else $error("lower gate or counter active in soft-start");
        oc_cut_a: assert property (upper_gate_drive[g] && ch_in[g].oc_cmp && !cyc_start[g]
            |=> !upper_gate_drive[g] ##0 s_q.ch[g].oc_seen)
            else $error("overcurrent did not end upper pulse");
        hiccup_cause_a: assert property ($past(s_q.ch[g].st) == CH_RUN && s_q.ch[g].st == CH_HICCUP
            |-> $past(s_q.ch[g].oc_cnt) == 6'h1f || $past(s_q.ch[g].uv_cnt) == 4'h7)
            else $error("hiccup without 32 overcurrent or 8 undervoltage cycles");
        ov_latch_a: assert property ($rose(s_q.ch[g].st == CH_OVLATCH)
            |-> $past(s_q.ch[g].ov_cnt) == 6'h1f && !gate_drive_oe[g] && !ss_discharge[g])
            else $error("overvoltage latch without 32 cycles or wrong pins");
        clean_cyc_a: assert property (cyc_start[g] && !s_q.ch[g].oc_seen
            |=> s_q.ch[g].oc_cnt == '0)
            else $error("overcurrent counter kept over a clean cycle");
        // clamp keeps the upper switch off while the lower one sinks the excess
        ov_clamp_a: assert property (s_q.ch[g].st == CH_RUN && ch_in[g].ov && !ch_in[g].ind_rev
            |=> s_q.ch[g].st != CH_RUN || (lower_gate_drive[g] && !upper_gate_drive[g]))
            else $error("overvoltage clamp not holding lower gate");
        latch_off_a: assert property (s_q.ch[g].st == CH_OVLATCH
            |-> !upper_gate_drive[g] && !lower_gate_drive[g] && !gate_drive_oe[g])
            else $error("gates still driven in overvoltage latch");
        hiccup_dis_a: assert property (s_q.ch[g].st == CH_HICCUP
            |-> ss_discharge[g] && !upper_gate_drive[g] && !lower_gate_drive[g])
            else $error("hiccup without soft-start discharge");
        latch_retry_a: assert property ($past(s_q.ch[g].st) == CH_OVLATCH && s_q.ch[g].st == CH_HICCUP
            |-> $past(s_q.ch[g].uv_cnt) == 4'h7)
            else $error("latch left for hiccup without 8 undervoltage cycles");
    end

    phase_half_a: assert property ($rose(upper_gate_drive[1])
        |-> $past(s_q.pcnt) == ($past(s_q.period) >> 1))
        else $error("channel 1 not started at half period");

    // the linear output only goes off with the power-on reset
    lin_hold_a: assert property (linear_drive_out |=> linear_drive_out)
        else $error("linear output switched off without reset");

    pg_good_c: cover property ($fell(power_good_oe));
    hiccup_c: cover property (s_q.ch[0].st == CH_RUN ##1 s_q.ch[0].st == CH_HICCUP);
    ovlatch_c: cover property (s_q.ch[0].st == CH_OVLATCH ##1 s_q.ch[0].st == CH_HICCUP);
    ov_entry_c: cover property (s_q.ch[0].st == CH_RUN ##1 s_q.ch[0].st == CH_OVLATCH);

endmodule : pgs_sequencer
`default_nettype wire

/* testbench/pgs_plant.sv */
// pgs_plant: one switcher's outside world: soft-start capacitor, power stage
// and feedback comparators, with fault knobs that the bench sets.
// assumes it is clocked by pclk and reset with the device's power-on reset.
`timescale 1ns/1ps
`default_nettype none
module pgs_plant
    import pgs_pkg::*;
#(
    parameter int RAMP_EN = 2,
    parameter int RAMP_DONE = 600,
    parameter int PULSE_W = 3
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // device side
    input wire logic ug,
    input wire logic dis,
    // fault knobs
    input wire logic en_hold,
    input wire logic f_oc,
    input wire logic f_uv,
    input wire logic f_ov,
    input wire logic win_bad,
    // comparator results
    output pgs_ch_in_t cmp
);
    logic [11:0] ramp_q;
    logic [3:0] on_q;
    // capacitor charges one step a cycle; ramp held short so hiccups stay cheap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_q <= '0;
            on_q <= '0;
        end else begin
            if (dis || en_hold) begin
                ramp_q <= '0;
            end else if (ramp_q < 12'(RAMP_DONE)) begin
                ramp_q <= ramp_q + 12'h001;
            end
            on_q <= ug ? on_q + 4'h1 : 4'h0;
        end
    end
    // comparators; window fails with any over or under fault
    always_comb begin
        cmp.ss_en = ramp_q >= 12'(RAMP_EN);
        cmp.ss_done = ramp_q >= 12'(RAMP_DONE);
        cmp.win_ok = cmp.ss_done && !f_uv && !f_ov && !win_bad;
        cmp.uv = f_uv;
        cmp.ov = f_ov;
        cmp.oc_cmp = f_oc && ug;
        cmp.pwm_end = on_q >= 4'(PULSE_W - 1);
        cmp.ind_rev = 1'b0;
    end
endmodule : pgs_plant
`default_nettype wire

/* testbench/tb_top.sv */
// tb_top: self-checking bench of the sequencer with two plant models.
// assumes the delay parameter is cut to 4 and CTRL sets a 16-cycle period.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pgs_pkg::*;
    localparam int PER = 16;
    localparam int PGD = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lin_ok;
    logic power_good_out, power_good_oe, linear_drive_out;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err;
    wire pgs_ch_in_t [1:0] ch_in;
    logic [1:0] upper_gate_drive, lower_gate_drive, gate_drive_oe, ss_discharge;
    logic [1:0] en_hold, f_oc, f_uv, f_ov, win_bad;
    int bad_count, comparisons, n;
    pgs_sequencer #(.PG_DELAY_CYC(PGD)) u_pgs_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ch_in(ch_in), .lin_ok(lin_ok), .upper_gate_drive(upper_gate_drive),
        .lower_gate_drive(lower_gate_drive), .gate_drive_oe(gate_drive_oe), .ss_discharge(ss_discharge),
        .power_good_out(power_good_out), .power_good_oe(power_good_oe), .linear_drive_out(linear_drive_out));
    for (genvar i = 0; i < 2; i++) begin : g_ch
        pgs_plant u_pgs_plant (.pclk(pclk), .presetn(presetn), .ug(upper_gate_drive[i]), .dis(ss_discharge[i]),
            .en_hold(en_hold[i]), .f_oc(f_oc[i]), .f_uv(f_uv[i]), .f_ov(f_ov[i]), .win_bad(win_bad[i]),
            .cmp(ch_in[i]));
    end
    // free-running 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    // apb master: setup, then access held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (!pready && k < 20);
        if (!pready) begin
            bad_count++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic cond(input int sel);
        case (sel)
            0: return power_good_oe === 1'b0;
            1: return ss_discharge[0] === 1'b1;
            2: return gate_drive_oe[0] === 1'b0;
            3: return ss_discharge[0] === 1'b0;
            4: return upper_gate_drive[0] === 1'b0;
            5: return upper_gate_drive[0] === 1'b1;
            default: return upper_gate_drive[1] === 1'b1;
        endcase
    endfunction : cond
    // bounded wait, counting edges; running out ends the run
    task automatic wait_on(input int sel, input int lim);
        n = 0;
        while (!cond(sel)) begin
            @(posedge pclk);
            #1;
            n++;
            if (n >= lim) begin
                bad_count++;
                end_of_test();
            end
        end
    endtask : wait_on
    task automatic in_range(input int lo, input int hi);
        check(32'(n >= lo && n <= hi), 32'h0000_0001);
    endtask : in_range
    task automatic recover();
        wait_on(3, 100);
        repeat (700) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0000_0000);
        check(32'(rd[6:4]), 32'h0000_0002);
    endtask : recover
    task automatic t_regs();
        apb(1'b0, 8'h04, 32'h0000_0000);
        check(32'(rd[1:0]), 32'h0000_0002);
        apb(1'b0, 8'h00, 32'h0000_0000);
        check(rd, 32'h0000_00fa);
        apb(1'b1, 8'h00, 32'h0000_0003);
        check(32'(err), 32'h0000_0001);
        apb(1'b1, 8'h04, 32'h0000_0010);
        check(32'(err), 32'h0000_0001);
        apb(1'b0, 8'h0c, 32'h0000_0000);
        check({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_0010);
        check(32'(err), 32'h0000_0000);
        apb(1'b0, 8'h00, 32'h0000_0000);
        check({rd[30:0], err}, 32'h0000_0020);
        $display("test registers done");
    endtask : t_regs
    task automatic t_pg();
        repeat (700) @(posedge pclk);
        win_bad <= 2'b10;
        repeat (6 * PER) @(posedge pclk);
        check(32'(power_good_oe), 32'h0000_0001);
        win_bad <= 2'b00;
        wait_on(0, PGD * PER + 3 * PER);
        in_range((PGD - 1) * PER, PGD * PER + 2);
        check(32'(power_good_out), 32'h0000_0000);
        lin_ok <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        check(32'(power_good_oe), 32'h0000_0001);
        apb(1'b0, 8'h08, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        lin_ok <= 1'b1;
        wait_on(0, PGD * PER + 3 * PER);
        in_range((PGD - 1) * PER, PGD * PER + 2);
        $display("test power good done");
    endtask : t_pg
    task automatic t_soft_oc();
        logic lg_seen, dis_seen, long_pulse, ug_prev;
        ug_prev = 1'b0;
        lg_seen = 1'b0;
        dis_seen = 1'b0;
        long_pulse = 1'b0;
        en_hold[0] <= 1'b1;
        f_oc[0] <= 1'b1;
        repeat (4) @(posedge pclk);
        en_hold[0] <= 1'b0;
        for (int k = 0; k < 800 && ch_in[0].ss_done !== 1'b1; k++) begin
            @(posedge pclk);
            #1;
            lg_seen |= lower_gate_drive[0];
            dis_seen |= ss_discharge[0];
            long_pulse |= upper_gate_drive[0] && ug_prev;
            ug_prev = upper_gate_drive[0];
        end
        check(32'(lg_seen), 32'h0000_0000);
        check(32'(dis_seen), 32'h0000_0000);
        check(32'(long_pulse), 32'h0000_0000);
        wait_on(1, 40 * PER);
        in_range(30 * PER, 34 * PER);
        wait_on(3, 100);
        wait_on(1, 1400);
        in_range(600, 1300);
        f_oc[0] <= 1'b0;
        recover();
        $display("test overcurrent done");
    endtask : t_soft_oc
    task automatic t_phase();
        wait_on(4, 3 * PER);
        wait_on(5, 3 * PER);
        wait_on(6, 2 * PER);
        check(32'(n), 32'(PER / 2));
        $display("test phase done");
    endtask : t_phase
    task automatic t_uv();
        f_uv[0] <= 1'b1;
        repeat (5 * PER) @(posedge pclk);
        f_uv[0] <= 1'b0;
        repeat (2 * PER) @(posedge pclk);
        f_uv[0] <= 1'b1;
        wait_on(1, 12 * PER);
        in_range(7 * PER, 9 * PER + 2);
        f_uv[0] <= 1'b0;
        recover();
        $display("test undervoltage done");
    endtask : t_uv
    task automatic t_ov();
        f_ov[0] <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        check(32'(lower_gate_drive[0]), 32'h0000_0001);
        wait_on(2, 40 * PER);
        in_range(30 * PER, 34 * PER);
        check(32'(ss_discharge[0]), 32'h0000_0000);
        apb(1'b0, 8'h04, 32'h0000_0000);
        check(32'(rd[6:4]), 32'h0000_0004);
        f_ov[0] <= 1'b0;
        f_uv[0] <= 1'b1;
        wait_on(1, 12 * PER);
        in_range(7 * PER, 9 * PER + 2);
        f_uv[0] <= 1'b0;
        recover();
        $display("test overvoltage done");
    endtask : t_ov
    // main sequence: reset 3 cycles, then every scenario in turn
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {en_hold, f_oc, f_uv, f_ov} = '0;
        win_bad = 2'b11;
        lin_ok = 1'b1;
        bad_count = 0;
        comparisons = 0;
        repeat (3) @(posedge pclk);
        check(32'(linear_drive_out), 32'h0000_0000);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        check(32'(linear_drive_out), 32'h0000_0001);
        t_regs();
        t_pg();
        t_soft_oc();
        t_phase();
        t_uv();
        t_ov();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
